// File: shared/ctm_pkg.sv
// shared constants for the compact timer mode logic
package ctm_pkg;
	localparam int          CNT_W            = 10;
	localparam int          COMPARE_P_VALUE_W           = 3;
	localparam logic [11:0] ADDR_CONTROL     = 12'h000;
	localparam logic [11:0] ADDR_COMPARE_A   = 12'h004;
	localparam logic [11:0] ADDR_COMPARE_P   = 12'h008;
	localparam logic [11:0] ADDR_TIMER_ON    = 12'h00C;
	localparam logic [11:0] ADDR_STATUS      = 12'h010;
	localparam logic [11:0] ADDR_COUNT       = 12'h014;
	localparam logic [7:0]  CONTROL_RESET    = 8'h00;
	localparam int          BIT_MODE_HI      = 7;
	localparam int          BIT_MODE_LO      = 6;
	localparam int          BIT_FUNC_HI      = 5;
	localparam int          BIT_FUNC_LO      = 4;
	localparam int          BIT_INIT_LEVEL   = 3;
	localparam int          BIT_INVERT       = 2;
	localparam int          BIT_SWAP         = 1;
	localparam int          BIT_CLEAR_SEL    = 0;
	localparam int          BIT_FLAG_A       = 0;
	localparam int          BIT_FLAG_P       = 1;
	localparam logic [1:0]  MODE_COMPARE     = 2'h0;
	localparam logic [1:0]  MODE_PWM         = 2'h2;
	localparam logic [1:0]  MODE_TIMER       = 2'h3;
	localparam logic [1:0]  FUNC_NONE        = 2'h0;
	localparam logic [1:0]  FUNC_LOW         = 2'h1;
	localparam logic [1:0]  FUNC_HIGH        = 2'h2;
	localparam logic [1:0]  FUNC_TOGGLE      = 2'h3;
	localparam logic [1:0]  PWM_INACTIVE     = 2'h0;
	localparam logic [1:0]  PWM_ACTIVE       = 2'h1;
	localparam logic [1:0]  PWM_WAVE         = 2'h2;
endpackage : ctm_pkg

// File: verilog/ctm_timer.sv
// compact 10-bit timer: mode, output and clear logic with apb registers
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ctm_timer #(
	parameter int CW = ctm_pkg::CNT_W,
	parameter int PW = ctm_pkg::COMPARE_P_VALUE_W
) (
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	input  wire logic        i_tick,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_timer_output_0,
	output logic             o_timer_output_1,
	output logic             o_output_enable
);
	import ctm_pkg::*;

	logic [7:0]    timer_mode_output_control;
	logic [CW-1:0] compare_a_value;
	logic [PW-1:0] compare_p_value;
	logic          timer_on;
	logic          timer_on_d;
	logic          match_a_flag;
	logic          match_p_flag;
	logic [CW-1:0] count;
	logic          pin_level;
	logic          pwm_level;

	logic [1:0] mode;
	logic [1:0] func;
	logic       init_level;
	logic       invert;
	logic       swap;
	logic       clear_sel;
	logic       is_pwm;
	logic       hit_a;
	logic       hit_p;
	logic       at_max;
	logic       period_hit;
	logic       duty_hit;
	logic       clear_now;
	logic       set_a;
	logic       set_p;
	logic       on_rise;
	logic       step;
	logic [CW:0] period_len;
	logic [CW:0] duty_len;
	logic       full_duty;
	logic       next_pin;
	logic       bus_wr;
	logic       bus_rd;
	logic       addr_ok;
	logic [31:0] next_prdata;

	// comparator P span in counter clocks; a zero word stands for the full span
	function automatic logic [CW:0] p_span(input logic [PW-1:0] p);
		if (p == '0)
			p_span = (CW + 1)'(1) << CW;
		else
			p_span = (CW + 1)'(p) << (CW - PW);
	endfunction : p_span

	assign mode       = {timer_mode_output_control[BIT_MODE_HI],
				timer_mode_output_control[BIT_MODE_LO]};
	assign func       = {timer_mode_output_control[BIT_FUNC_HI],
				timer_mode_output_control[BIT_FUNC_LO]};
	assign init_level = timer_mode_output_control[BIT_INIT_LEVEL];
	assign invert     = timer_mode_output_control[BIT_INVERT];
	assign swap       = timer_mode_output_control[BIT_SWAP];
	assign clear_sel  = timer_mode_output_control[BIT_CLEAR_SEL];
	// mode 01 decodes as none of the three and only holds the pins
	assign is_pwm     = (mode == MODE_PWM);

	// comparators look at count + 1, the value the count is about to step to
	assign step    = timer_on && timer_on_d && i_tick;
	assign on_rise = timer_on && !timer_on_d;
	assign at_max  = (count == {CW{1'b1}});
	// compare A of zero matches at the wrap from 3FF
	assign hit_a   = step && (count + 1'b1 == compare_a_value);
	// P matches only the first count of its block, so the flag pulses once
	assign hit_p   = step && (compare_p_value != '0) &&
			(count + 1'b1 == CW'(compare_p_value) << (CW - PW));

	// period register chosen by swap; P zero means full counter span
	assign period_len = swap ? {1'b0, compare_a_value}
			: p_span(compare_p_value);
	assign duty_len   = swap ? p_span(compare_p_value)
			: {1'b0, compare_a_value};
	assign full_duty  = (duty_len >= period_len);
	assign period_hit = swap ? hit_a : (hit_p || (compare_p_value == '0 && step && at_max));
	assign duty_hit   = swap ? hit_p : hit_a;

	// pwm ignores clear select; the period register alone restarts it
	always_comb
	begin
		if (is_pwm)
			clear_now = period_hit;
		else if (clear_sel)
			clear_now = hit_a || (step && at_max);
		else
			clear_now = hit_p || (step && at_max && compare_p_value == '0);
	end

	// a zero compare A word still clears at overflow but raises no flag
	assign set_a = hit_a && (compare_a_value != '0);
	assign set_p = hit_p && (is_pwm || !clear_sel);

	// a rise of timer_on beats a match in the same cycle
	always_comb
	begin
		next_pin = pin_level;
		if (on_rise)
			next_pin = init_level;
		else if (set_a)
		begin
			unique case (func)
				FUNC_NONE:   next_pin = pin_level;
				FUNC_LOW:    next_pin = 1'b0;
				FUNC_HIGH:   next_pin = 1'b1;
				FUNC_TOGGLE: next_pin = !pin_level;
			endcase
		end
	end

	// delay starts low like timer_on, so reset leaves no false rise
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			timer_on_d <= 1'b0;
		else
			timer_on_d <= timer_on;
	end

	// counter only cleared by timer_on rise, a selected match or overflow
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			count <= '0;
		else if (on_rise)
			count <= '0;
		else if (clear_now)
			count <= '0;
		else if (step)
			count <= count + 1'b1;
	end

	// compare- and timer-mode pin state; a timer_on rise loads init_level, then only comparator A moves it
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			pin_level <= 1'b0;
		else if (mode == MODE_COMPARE || mode == MODE_TIMER)
			pin_level <= next_pin;
	end

	// pwm wave in active terms: active after period clear, inactive at duty match
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			pwm_level <= 1'b0;
		else if (on_rise || period_hit)
			pwm_level <= 1'b1;
		else if (duty_hit && !full_duty)
			pwm_level <= 1'b0;
	end

	// drive the pins; undefined codes keep the last level
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_timer_output_0 <= 1'b0;
			o_timer_output_1 <= 1'b1;
			o_output_enable  <= 1'b0;
		end
		else
		begin
			unique case (mode)
				MODE_COMPARE:
				begin
					o_timer_output_0 <= next_pin ^ invert;
					o_timer_output_1 <= !(next_pin ^ invert);
					o_output_enable  <= 1'b1;
				end
				MODE_PWM:
				begin
					o_output_enable <= 1'b1;
					if (func != FUNC_TOGGLE)
					begin
						// active level is init_level, so xor maps active->pin
						o_timer_output_0 <= ((func == PWM_ACTIVE) ||
							(func == PWM_WAVE && (pwm_level || full_duty))) ^
							!init_level ^ invert;
						o_timer_output_1 <= !(((func == PWM_ACTIVE) ||
							(func == PWM_WAVE && (pwm_level || full_duty))) ^
							!init_level ^ invert);
					end
				end
				// timer mode frees the pin; the last level is kept for a switch back
				MODE_TIMER:
					o_output_enable <= 1'b0;
				default:
					o_output_enable <= o_output_enable;
			endcase
		end
	end

	// unaligned or unmapped addresses answer with an error
	assign addr_ok = (i_paddr == ADDR_CONTROL) || (i_paddr == ADDR_COMPARE_A) ||
			(i_paddr == ADDR_COMPARE_P) || (i_paddr == ADDR_TIMER_ON) ||
			(i_paddr == ADDR_STATUS) || (i_paddr == ADDR_COUNT);
	assign bus_wr  = i_psel && i_penable && i_pwrite && o_pready;
	assign bus_rd  = i_psel && !i_penable && !i_pwrite;

	// words take effect at once; software stops the timer before reshaping it
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			timer_mode_output_control <= CONTROL_RESET;
		else if (bus_wr && i_paddr == ADDR_CONTROL)
			timer_mode_output_control <= i_pwdata[7:0];
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			compare_a_value <= '0;
		else if (bus_wr && i_paddr == ADDR_COMPARE_A)
			compare_a_value <= i_pwdata[CW-1:0];
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			compare_p_value <= '0;
		else if (bus_wr && i_paddr == ADDR_COMPARE_P)
			compare_p_value <= i_pwdata[PW-1:0];
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			timer_on <= 1'b0;
		else if (bus_wr && i_paddr == ADDR_TIMER_ON)
			timer_on <= i_pwdata[0];
	end

	// flags: write one to clear; a new match in the same cycle wins
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			match_a_flag <= 1'b0;
		else if (set_a)
			match_a_flag <= 1'b1;
		else if (bus_wr && i_paddr == ADDR_STATUS && i_pwdata[BIT_FLAG_A])
			match_a_flag <= 1'b0;
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			match_p_flag <= 1'b0;
		else if (set_p)
			match_p_flag <= 1'b1;
		else if (bus_wr && i_paddr == ADDR_STATUS && i_pwdata[BIT_FLAG_P])
			match_p_flag <= 1'b0;
	end

	// read word chosen in setup so it stands through the access cycle
	always_comb
	begin
		next_prdata = o_prdata;
		if (bus_rd)
		begin
			unique case (1'b1)
				i_paddr == ADDR_CONTROL:   next_prdata = {24'h000000, timer_mode_output_control};
				i_paddr == ADDR_COMPARE_A: next_prdata = 32'(compare_a_value);
				i_paddr == ADDR_COMPARE_P: next_prdata = 32'(compare_p_value);
				i_paddr == ADDR_TIMER_ON:  next_prdata = 32'(timer_on);
				i_paddr == ADDR_STATUS:    next_prdata = {30'h00000000, match_p_flag, match_a_flag};
				i_paddr == ADDR_COUNT:     next_prdata = 32'(count);
				default:                   next_prdata = '0;
			endcase
		end
	end

	// no wait state: data latched in setup, ready in first access cycle
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_prdata  <= '0;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready  <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !addr_ok;
			o_prdata  <= next_prdata;
		end
	end
endmodule : ctm_timer
`default_nettype wire

// File: tb/ctm_load.sv
// external load on the timer pins: counts active-high cycles
`timescale 1ns/1ps
`default_nettype none
module ctm_load (
	input  wire logic i_clock,
	input  wire logic i_clear,
	input  wire logic i_pin_0,
	input  wire logic i_pin_1,
	input  wire logic i_drive,
	output var int    o_high
);
	// an undriven or non-complementary pair is not a valid level
	always @(posedge i_clock)
		if (i_clear)
			o_high <= 0;
		else if (i_drive && i_pin_0 === 1'b1 && i_pin_1 === 1'b0)
			o_high <= o_high + 1;
endmodule : ctm_load
`default_nettype wire

// File: tb/ctm_assertions.sv
// bus and pin checks for the compact timer
`timescale 1ns/1ps
`default_nettype none
module ctm_checker
	import ctm_pkg::*;
(
	input wire logic        i_clock,
	input wire logic        i_rstn,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_timer_output_0,
	input wire logic        o_timer_output_1,
	input wire logic        o_output_enable
);
	logic ctl_wr;
	assign ctl_wr = o_pready && i_pwrite && i_paddr == ADDR_CONTROL;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	pins_inverse_a: assert property (o_timer_output_1 == !o_timer_output_0)
		else $error("pins not complementary");
	apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("ready too long");
	err_unmapped_a: assert property (o_pready && i_paddr > ADDR_COUNT |-> o_pslverr)
		else $error("no error on unmapped");
	err_mapped_a: assert property (o_pready && i_paddr <= ADDR_COUNT |-> !o_pslverr)
		else $error("error on mapped");
	err_zero_a: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
		else $error("data on refused read");
	timer_pin_off_a: assert property (
		ctl_wr && i_pwdata[7:6] == MODE_TIMER |-> ##[1:3] !o_output_enable)
		else $error("pin driven in timer mode");
	pwm_pin_on_a: assert property (
		ctl_wr && i_pwdata[7:6] == MODE_PWM |-> ##[1:3] o_output_enable)
		else $error("pin idle in pwm mode");
	cover property (o_pslverr);
	cover property ($rose(o_timer_output_0) && o_output_enable);
	cover property ($fell(o_timer_output_0) && o_output_enable);
endmodule : ctm_checker
bind ctm_timer ctm_checker chk_u (.*);
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the compact timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ctm_pkg::*;
	logic        i_clock    = 1'b0;
	logic        i_rstn     = 1'b0;
	logic        i_tick     = 1'b1;
	logic        i_psel     = 1'b0;
	logic        i_penable  = 1'b0;
	logic        i_pwrite   = 1'b0;
	logic [11:0] i_paddr    = 12'h0;
	logic [31:0] i_pwdata   = 32'h0;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic        o_timer_output_0;
	logic        o_timer_output_1;
	logic        o_output_enable;
	logic        ld_clr     = 1'b0;
	int          ld_high;
	int          mismatches = 0;
	int          checked    = 0;
	int          cyc        = 0;
	logic [31:0] rd;
	logic        er;
	logic [9:0]  a;
	logic [7:0]  c;
	logic        v;
	logic        e;
	ctm_timer dut_u (.*);
	ctm_load load_u (.i_clock(i_clock), .i_clear(ld_clr), .i_pin_0(o_timer_output_0),
		.i_pin_1(o_timer_output_1), .i_drive(o_output_enable), .o_high(ld_high));
	initial forever #25 i_clock = ~i_clock;
	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge i_clock);
	endtask : wt
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		@(posedge i_clock);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= w;
		i_paddr   <= ad;
		i_pwdata  <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		n = 0;
		@(posedge i_clock);
		while (o_pready !== 1'b1 && n < 16)
		begin
			@(posedge i_clock);
			n++;
		end
		rd = o_prdata;
		er = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
		if (n >= 16)
			chk(32'h0, 32'h1);
	endtask : apb
	task rdchk(input logic [11:0] ad, input logic [31:0] x);
		apb(1'b0, ad, 32'h0);
		chk(rd, x);
	endtask : rdchk
	// software side: timer always stopped before the control word changes
	task cfg(input logic [7:0] cw, input logic [9:0] ca, input logic [2:0] cp);
		apb(1'b1, ADDR_TIMER_ON, 32'h0);
		apb(1'b1, ADDR_STATUS, 32'h3);
		apb(1'b1, ADDR_CONTROL, {24'h0, cw});
		apb(1'b1, ADDR_COMPARE_A, {22'h0, ca});
		apb(1'b1, ADDR_COMPARE_P, {29'h0, cp});
		apb(1'b1, ADDR_TIMER_ON, 32'h1);
	endtask : cfg
	function automatic int hi_cnt(logic [7:0] cw, int ca, int cp, int win);
		int per;
		int dty;
		per = cw[1] ? ca : (cp == 0 ? 1024 : 128 * cp);
		dty = cw[1] ? (cp == 0 ? 1024 : 128 * cp) : ca;
		dty = (cw[5:4] == 2'h0) ? 0 : (cw[5:4] == 2'h1 || dty >= per) ? per : dty;
		return (win / per) * ((cw[3] ^ cw[2]) ? dty : per - dty);
	endfunction : hi_cnt
	// window is a whole number of periods, so its phase does not matter
	task pwm(input logic [7:0] cw, input int ca, input int cp, input int win,
		input logic [31:0] st);
		cfg(cw, 10'(ca), 3'(cp));
		wt(8);
		ld_clr <= 1'b1;
		wt(1);
		ld_clr <= 1'b0;
		wt(win + 1);
		chk(ld_high, hi_cnt(cw, ca, cp, win));
		if (st !== 32'hF)
			rdchk(ADDR_STATUS, st);
	endtask : pwm
	initial
	begin
		void'($urandom(41590));
		repeat (10) @(posedge i_clock);
		i_rstn <= 1'b1;
		for (int k = 0; k < 6; k++)
			rdchk(12'(4 * k), 32'h0);
		apb(1'b1, 12'h018, 32'h5A);
		chk(er, 1'b1);
		apb(1'b0, 12'h018, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		c = 8'($urandom);
		apb(1'b1, ADDR_CONTROL, {24'h0, c});
		rdchk(ADDR_CONTROL, {24'h0, c});
		$display("registers done");
		for (int i = 0; i < 8; i++)
		begin
			a = 10'd20 + 10'($urandom % 81);
			v = 1'($urandom);
			c = {2'b00, 3'(i), v, 2'b00};
			e = (i[2:1] == 2'd0) ? i[0] : (i[2:1] == 2'd3) ? !i[0] : i[2];
			cfg(c, a, 3'h1);
			wt(5);
			chk(o_timer_output_0, i[0] ^ v);
			wt(110);
			chk(o_timer_output_0, e ^ v);
			wt(20);
			chk(o_timer_output_0, e ^ v);
		end
		rdchk(ADDR_STATUS, 32'h3);
		cfg(8'h01, 10'd50, 3'h1);
		wt(300);
		rdchk(ADDR_STATUS, 32'h1);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk(rd <= 32'd50, 1'b1);
		cfg(8'h01, 10'd0, 3'h0);
		wt(300);
		rdchk(ADDR_STATUS, 32'h0);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk(rd >= 32'd290, 1'b1);
		cfg(8'hC0, 10'd50, 3'h1);
		wt(200);
		rdchk(ADDR_STATUS, 32'h3);
		chk(o_output_enable, 1'b0);
		apb(1'b1, ADDR_TIMER_ON, 32'h0);
		apb(1'b0, ADDR_COUNT, 32'h0);
		a = rd[9:0];
		wt(40);
		rdchk(ADDR_COUNT, {22'h0, a});
		$display("compare and timer modes done");
		pwm(8'hA9, 32, 1, 256, 32'h3);
		pwm(8'hAC, 32, 1, 256, 32'h3);
		pwm(8'hA8, 200, 1, 256, 32'h2);
		pwm(8'hAA, 300, 1, 600, 32'h3);
		pwm(8'h88, 32, 1, 256, 32'h3);
		pwm(8'h98, 32, 1, 256, 32'h3);
		pwm(8'hA8, 32, 0, 1024, 32'hF);
		$display("pwm mode done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
